// ==== include/cbd_pkg.sv ====
// Constants, register map and types for the core bus and debug pin block
package cbd_pkg;
   // Register bus geometry
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_WDATA = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_RDATA = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
   // Control register fields
   localparam int CTRL_RESUME_BIT = 0;
   localparam int CTRL_DBGREQ_BIT = 1;
   localparam logic CTRL_DBGREQ_RST = 1'h0;
   // Command register field and opcodes
   localparam int CMD_OP_LSB = 0;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_COPROC = 2'h3;
   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DEBUG_BIT = 1;
   localparam int ST_ABSENT_BIT = 2;
   localparam int ST_REFUSED_BIT = 3;
   localparam int ST_BUSCFG_BIT = 4;
   localparam int ST_DBE_BIT = 5;
   localparam int ST_DEBUG_FEATURE_ENABLE_BIT = 6;
   // Reset values of data registers
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing: system clock and memory clock half period
   localparam int CLK_PERIOD_NS = 100;
   localparam int MCLK_HALF_NS = 200;
   localparam int MCLK_HALF_CYC = MCLK_HALF_NS / CLK_PERIOD_NS;
   // Memory and coprocessor cycle sequencer, Gray coded
   typedef enum logic [1:0] {
      CBD_IDLE = 2'b00,
      CBD_WAIT = 2'b01,
      CBD_HIGH = 2'b11,
      CBD_LOW = 2'b10
   } cbd_state_t;
   // Word address decode shared by read and write paths
   function automatic logic cbd_addr_ok(input logic [ADDR_W-1:0] a);
      cbd_addr_ok = (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_WDATA) ||
         (a == ADDR_RDATA) || (a == ADDR_STATUS);
   endfunction
endpackage

// ==== verification/cbd_far_model.sv ====
// Far side model: memory system and coprocessor
`timescale 1ns/10ps
`default_nettype none
module cbd_far_model (
   input wire logic CLK,
   input wire logic MEM_CLK,
   input wire logic MEM_WRITE,
   input wire logic [31:0] DATA_BUS_O,
   input wire logic DATA_BUS_OE,
   input wire logic [31:0] DATA_OUT_BUS,
   input wire logic COPROC_INSTR_OUT_N,
   input wire logic cfg,
   input wire logic [31:0] rd_word,
   input wire logic [3:0] busy_len,
   input wire logic absent,
   output logic [31:0] DATA_BUS_I,
   output logic [31:0] DATA_IN_BUS,
   output logic COPROC_BUSY_IN,
   output logic COPROC_ABSENT_IN,
   output logic [31:0] wr_seen
);
   logic mem_clk_q = 1'b0;
   logic [3:0] busy_cnt = 4'h0;
   logic reading;
   // Memory answers when the core has let go of the shared bus and is not writing
   assign reading = !DATA_BUS_OE && !MEM_WRITE;
   // read data ahead of fall
   // Shared bus carries the inverted read word when the split buses are in use
   assign DATA_BUS_I = DATA_BUS_OE ? DATA_BUS_O : ((reading && !cfg) ? rd_word : ~rd_word);
   assign DATA_IN_BUS = !cfg ? 32'h0 : (reading ? rd_word : ~rd_word);
   always @(posedge CLK) begin
      if (COPROC_INSTR_OUT_N)
         busy_cnt <= busy_len;
      else if (busy_cnt != 4'h0)
         busy_cnt <= busy_cnt - 4'h1;
   end
   assign COPROC_BUSY_IN = busy_cnt != 4'h0;
   assign COPROC_ABSENT_IN = absent;
   always @(posedge CLK) begin
      mem_clk_q <= MEM_CLK;
      if (mem_clk_q && !MEM_CLK && MEM_WRITE)
         wr_seen <= cfg ? DATA_OUT_BUS : (DATA_BUS_OE ? DATA_BUS_O : 32'h0);
   end
endmodule
`default_nettype wire

// ==== verification/cbd_top_sva.sv ====
// Pin behaviour checker for the core bus and debug block
`timescale 1ns/10ps
`default_nettype none
module cbd_top_sva import cbd_pkg::*; #(
   parameter int HALF_CYC = MCLK_HALF_CYC
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MEM_CLK,
   input wire logic MEM_WRITE,
   input wire logic [31:0] DATA_BUS_O,
   input wire logic DATA_BUS_OE,
   input wire logic [31:0] DATA_OUT_BUS,
   input wire logic BUS_CONFIG_SELECT,
   input wire logic DATA_OUTPUT_ENABLE,
   input wire logic COPROC_INSTR_OUT_N,
   input wire logic COPROC_BUSY_IN,
   input wire logic COPROC_ABSENT_IN,
   input wire logic DEBUG_ACK_OUT,
   input wire logic DEBUG_FEATURE_ENABLE,
   input wire logic EXT_DEBUG_REQUEST,
   input wire logic INTERNAL_DEBUG_REQUEST_OUT
);
   logic [2:0] rel_cnt_r;
   logic [2:0] rel_cnt_nxt;
   logic settled;
   // Longest coprocessor verdict wait once the pins are steady: two memory clock periods
   localparam int CP_MAX = 4 * HALF_CYC;
   // Cycles since reset release; pins count as settled after five edges
   assign rel_cnt_nxt = (rel_cnt_r == 3'h7) ? rel_cnt_r : rel_cnt_r + 3'h1;
   assign settled = rel_cnt_r > 3'h4;
   always_ff @(posedge CLK) begin
      rel_cnt_r <= SYS_RST ? 3'h0 : rel_cnt_nxt;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   AST_IDBG_EXT: assert property (EXT_DEBUG_REQUEST[*4] ##0 settled |-> INTERNAL_DEBUG_REQUEST_OUT)
      else $error("internal request low under external request");
   AST_ACK_OFF: assert property (!DEBUG_FEATURE_ENABLE[*4] ##0 settled |-> !DEBUG_ACK_OUT)
      else $error("debug acknowledge high while disabled");
   AST_ACK_REQ: assert property ((DEBUG_FEATURE_ENABLE && EXT_DEBUG_REQUEST && COPROC_INSTR_OUT_N
      && !MEM_WRITE)[*4] |-> ##[0:12] DEBUG_ACK_OUT)
      else $error("debug state not entered on request");
   AST_OE_OFF: assert property (!DATA_OUTPUT_ENABLE[*4] ##0 settled |-> !DATA_BUS_OE && DATA_OUT_BUS == 32'h0)
      else $error("data driven while data enable low");
   AST_DOUT_ZERO: assert property (!BUS_CONFIG_SELECT[*4] ##0 settled |-> DATA_OUT_BUS == 32'h0)
      else $error("output bus not zero in shared bus mode");
   AST_OE_WRITE: assert property (DATA_OUTPUT_ENABLE[*4] ##0 settled && MEM_WRITE |-> DATA_BUS_OE)
      else $error("shared bus not driven in write cycle");
   AST_WR_HOLD: assert property (MEM_WRITE && $past(MEM_WRITE) |-> $stable(DATA_BUS_O) && $stable(DATA_OUT_BUS))
      else $error("write data changed in write cycle");
   AST_WR_FALL: assert property ($fell(MEM_CLK) && MEM_WRITE |=> MEM_WRITE)
      else $error("write cycle ended at memory clock fall");
   AST_CP_WAIT: assert property ((COPROC_BUSY_IN && !COPROC_ABSENT_IN)[*4] ##0 !COPROC_INSTR_OUT_N && settled
      |=> !COPROC_INSTR_OUT_N)
      else $error("coprocessor operation ended while busy");
   AST_CP_DONE: assert property ((!COPROC_BUSY_IN || COPROC_ABSENT_IN)[*4] ##0 !COPROC_INSTR_OUT_N
      |-> ##[1:CP_MAX] COPROC_INSTR_OUT_N)
      else $error("coprocessor operation not ended");
   // Main scenarios reached
   COV_CP: cover property (!COPROC_INSTR_OUT_N ##1 COPROC_INSTR_OUT_N);
   COV_DBG: cover property ($rose(DEBUG_ACK_OUT));
   COV_WR: cover property ($fell(MEM_CLK) && MEM_WRITE);
endmodule
bind cbd_top cbd_top_sva #(.HALF_CYC(HALF_CYC)) u_sva (.CLK, .SYS_RST, .MEM_CLK, .MEM_WRITE, .DATA_BUS_O,
   .DATA_BUS_OE, .DATA_OUT_BUS, .BUS_CONFIG_SELECT, .DATA_OUTPUT_ENABLE, .COPROC_INSTR_OUT_N, .COPROC_BUSY_IN,
   .COPROC_ABSENT_IN, .DEBUG_ACK_OUT, .DEBUG_FEATURE_ENABLE, .EXT_DEBUG_REQUEST, .INTERNAL_DEBUG_REQUEST_OUT);
`default_nettype wire

// ==== verification/cbd_top_tb.sv ====
// Self-checking testbench for the core bus and debug block
`timescale 1ns/10ps
`default_nettype none
module cbd_top_tb import cbd_pkg::*;;
   logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, MEM_CLK, MEM_WRITE, DATA_BUS_OE, absent;
   logic BUS_CONFIG_SELECT, DATA_OUTPUT_ENABLE, COPROC_INSTR_OUT_N, COPROC_BUSY_IN, COPROC_ABSENT_IN;
   logic DEBUG_ACK_OUT, DEBUG_FEATURE_ENABLE, EXT_DEBUG_REQUEST, INTERNAL_DEBUG_REQUEST_OUT;
   logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, DATA_BUS_I, DATA_BUS_O, DATA_IN_BUS, DATA_OUT_BUS;
   logic [31:0] rd_word, wr_seen, rng, v;
   logic [3:0] S_AXI_WSTRB, busy_len;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
   int failures = 0;
   int num_checks = 0;
   cbd_top #(.HALF_CYC(2)) dut (.CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
      .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MEM_CLK,
      .MEM_WRITE, .DATA_BUS_I, .DATA_BUS_O, .DATA_BUS_OE, .DATA_IN_BUS, .DATA_OUT_BUS, .BUS_CONFIG_SELECT,
      .DATA_OUTPUT_ENABLE, .COPROC_INSTR_OUT_N, .COPROC_BUSY_IN, .COPROC_ABSENT_IN, .DEBUG_ACK_OUT,
      .DEBUG_FEATURE_ENABLE, .EXT_DEBUG_REQUEST, .INTERNAL_DEBUG_REQUEST_OUT);
   cbd_far_model far (.CLK, .MEM_CLK, .MEM_WRITE, .DATA_BUS_O, .DATA_BUS_OE, .DATA_OUT_BUS, .COPROC_INSTR_OUT_N,
      .cfg(BUS_CONFIG_SELECT), .rd_word, .busy_len, .absent, .DATA_BUS_I, .DATA_IN_BUS, .COPROC_BUSY_IN,
      .COPROC_ABSENT_IN, .wr_seen);
   // Clock source
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   // Repeatable random words
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   // Comparison and verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Expected far-side write word: suppressed without data enable
   function automatic logic [31:0] exp_wr(input logic en, input logic [31:0] w);
      exp_wr = en ? w : 32'h0;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // Register write: address and data offered together, each dropped once taken
   task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge CLK);
         if (S_AXI_AWVALID && S_AXI_AWREADY)
            aw_ok = 1'b1;
         if (S_AXI_WVALID && S_AXI_WREADY)
            w_ok = 1'b1;
         if (aw_ok)
            S_AXI_AWVALID <= 1'b0;
         if (w_ok)
            S_AXI_WVALID <= 1'b0;
      end
      while (!S_AXI_BVALID) @(posedge CLK);
      resp = S_AXI_BRESP;
   endtask
   // Register read
   task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do @(posedge CLK); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK); while (!S_AXI_RVALID);
      d = S_AXI_RDATA;
      resp = S_AXI_RRESP;
   endtask
   task automatic idle();
      v = 32'h1;
      while (v[ST_BUSY_BIT]) axr(ADDR_STATUS, v);
   endtask
   // Main sequence
   initial begin
      rng = 32'h0000_1c7f;
      SYS_RST = 1'b1;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, EXT_DEBUG_REQUEST, DEBUG_FEATURE_ENABLE} = 5'h00;
      {S_AXI_BREADY, S_AXI_RREADY, DATA_OUTPUT_ENABLE, BUS_CONFIG_SELECT, absent} = 5'h1c;
      S_AXI_AWADDR = 5'h00;
      S_AXI_ARADDR = 5'h00;
      S_AXI_WDATA = 32'h0;
      S_AXI_WSTRB = 4'hf;
      rd_word = 32'h0;
      busy_len = 4'h0;
      repeat (6) @(posedge CLK);
      SYS_RST <= 1'b0;
      cyc(4);
      axr(ADDR_CTRL, v);
      check("ctrl reset", v, 32'h0);
      axr(ADDR_RDATA, v);
      check("rdata reset", v, DATA_RST);
      S_AXI_WSTRB <= 4'h3;
      axw(ADDR_WDATA, 32'hffff_ffff);
      S_AXI_WSTRB <= 4'hf;
      axr(ADDR_WDATA, v);
      check("byte lanes", v, 32'h0000_ffff);
      axr(5'h14, v);
      check("unmapped read", resp, RESP_SLVERR);
      axw(5'h18, 32'h5);
      check("unmapped write", resp, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         EXT_DEBUG_REQUEST <= i[1];
         axw(ADDR_CTRL, {30'h0, i[0], 1'b0});
         cyc(4);
         check("internal request", INTERNAL_DEBUG_REQUEST_OUT, i[1] | i[0]);
         check("ack disabled", DEBUG_ACK_OUT, 1'b0);
      end
      DEBUG_FEATURE_ENABLE <= 1'b1;
      cyc(6);
      check("ack on request", DEBUG_ACK_OUT, 1'b1);
      axw(ADDR_CMD, {30'h0, OP_READ});
      axr(ADDR_STATUS, v);
      check("debug status", v[ST_DEBUG_BIT], 1'b1);
      check("refused in debug", v[ST_REFUSED_BIT], 1'b1);
      EXT_DEBUG_REQUEST <= 1'b0;
      axw(ADDR_CTRL, 32'h0);
      axw(ADDR_CTRL, 32'h1);
      cyc(2);
      check("ack after resume", DEBUG_ACK_OUT, 1'b0);
      EXT_DEBUG_REQUEST <= 1'b1;
      cyc(6);
      DEBUG_FEATURE_ENABLE <= 1'b0;
      EXT_DEBUG_REQUEST <= 1'b0;
      cyc(4);
      check("ack after disable", DEBUG_ACK_OUT, 1'b0);
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         BUS_CONFIG_SELECT <= k[0];
         DATA_OUTPUT_ENABLE <= (k < 4);
         rd_word <= rng;
         cyc(4);
         if (k < 2) begin
            axw(ADDR_CMD, {30'h0, OP_READ});
            idle();
            axr(ADDR_RDATA, v);
            check("read word", v, rng);
         end else begin
            axw(ADDR_WDATA, rng);
            axw(ADDR_CMD, {30'h0, OP_WRITE});
            idle();
            check("written word", wr_seen, exp_wr(k < 4, rng));
         end
      end
      DATA_OUTPUT_ENABLE <= 1'b1;
      cyc(4);
      check("idle drive", DATA_BUS_OE, 1'b1);
      for (int c = 0; c < 3; c++) begin
         rng = xs(rng);
         absent <= (c == 2);
         busy_len <= (c == 0) ? 4'h0 : {1'b1, rng[2:0]};
         cyc(4);
         axw(ADDR_CMD, {30'h0, OP_COPROC});
         axw(ADDR_CMD, {30'h0, OP_NONE});
         axr(ADDR_STATUS, v);
         check("empty command", v[ST_REFUSED_BIT], 1'b1);
         check("coproc waiting", v[ST_BUSY_BIT], c == 1);
         idle();
         check("absent result", v[ST_ABSENT_BIT], c == 2);
      end
      summarize();
   end
   // Watchdog, well beyond the few hundred cycles the sequence needs
   initial begin
      #3000000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire

// ==== verilog/cbd_axil.sv ====
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
`default_nettype none
module cbd_axil import cbd_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data
);
   logic aw_hold_r, w_hold_r, rd_pend_r;
   wire aw_fire = awvalid & awready;
   wire w_fire = wvalid & wready;
   wire both = aw_hold_r & w_hold_r & ~bvalid;

   // Write path: address and data in either order, then response
   always_ff @(posedge clk) begin
      if (rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wr_en <= 1'b0;
         wr_addr <= '0;
         wr_data <= DATA_RST;
         wr_strb <= 4'h0;
      end else begin
         wr_en <= both & cbd_addr_ok(wr_addr);
         if (aw_fire) begin
            aw_hold_r <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
         end
         if (w_fire) begin
            w_hold_r <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (both) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= cbd_addr_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid & bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Read path: latch address, answer one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         arready <= 1'b1;
         rd_pend_r <= 1'b0;
         rd_addr <= '0;
         rvalid <= 1'b0;
         rdata <= DATA_RST;
         rresp <= RESP_OKAY;
      end else if (arvalid & arready) begin
         arready <= 1'b0;
         rd_addr <= araddr;
         rd_pend_r <= 1'b1;
      end else if (rd_pend_r) begin
         rd_pend_r <= 1'b0;
         rvalid <= 1'b1;
         rdata <= cbd_addr_ok(rd_addr) ? rd_data : DATA_RST;
         rresp <= cbd_addr_ok(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid & rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/cbd_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cbd_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/cbd_top.sv ====
// Core data bus, coprocessor handshake and debug pin logic
// What this block does
// - Sample busy on memory clock rise, instruction low
// - Write data held past the falling edge
// - Drive shared bus except during read cycles
// - Data output only while data enable high
// - Enable low: shared bus floats, output suppressed
// - Debug acknowledge high throughout debug state
// - Debug enable low blocks debug state and acknowledge; internal request still driven
// - Debug request enters debug after current operation
// - Internal request is external OR control bit 1
// - Sample input bus on falling edge when reading
// - Config low: shared bus, output bus zero
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cbd_top import cbd_pkg::*; #(
   parameter int HALF_CYC = MCLK_HALF_CYC
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic MEM_CLK,
   output logic MEM_WRITE,
   input wire logic [31:0] DATA_BUS_I,
   output logic [31:0] DATA_BUS_O,
   output logic DATA_BUS_OE,
   input wire logic [31:0] DATA_IN_BUS,
   output logic [31:0] DATA_OUT_BUS,
   input wire logic BUS_CONFIG_SELECT,
   input wire logic DATA_OUTPUT_ENABLE,
   output logic COPROC_INSTR_OUT_N,
   input wire logic COPROC_BUSY_IN,
   input wire logic COPROC_ABSENT_IN,
   output logic DEBUG_ACK_OUT,
   input wire logic DEBUG_FEATURE_ENABLE,
   input wire logic EXT_DEBUG_REQUEST,
   output logic INTERNAL_DEBUG_REQUEST_OUT
);
   // Refuse a memory clock that cannot be built
   if (HALF_CYC < 1) begin : g_chk
      $error("HALF_CYC must be at least one");
   end

   // Bus front end wires
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;

   cbd_axil u_axil (
      .clk(CLK),
      .rst(SYS_RST),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Pin inputs pass two flip-flops first
   localparam int NCTL = 6;
   logic [NCTL-1:0] ctl_s;
   logic [31:0] dbus_s;
   logic [31:0] din_s;

   cbd_sync #(.W(NCTL)) u_sync_ctl (
      .clk(CLK),
      .rst(SYS_RST),
      .d({COPROC_BUSY_IN, COPROC_ABSENT_IN, BUS_CONFIG_SELECT,
          DATA_OUTPUT_ENABLE, DEBUG_FEATURE_ENABLE, EXT_DEBUG_REQUEST}),
      .q(ctl_s)
   );

   cbd_sync #(.W(32)) u_sync_dbus (
      .clk(CLK),
      .rst(SYS_RST),
      .d(DATA_BUS_I),
      .q(dbus_s)
   );

   cbd_sync #(.W(32)) u_sync_din (
      .clk(CLK),
      .rst(SYS_RST),
      .d(DATA_IN_BUS),
      .q(din_s)
   );

   // Named views of the synchronised control pins
   wire busy_s = ctl_s[5];
   wire absent_s = ctl_s[4];
   wire bus_cfg_s = ctl_s[3];
   wire dbe_s = ctl_s[2];
   wire dbg_en_s = ctl_s[1];
   wire ext_req_s = ctl_s[0];

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   // Memory clock divider: one enable pulse per half period
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);
   logic [CW-1:0] div_r;
   wire phase_en = (div_r == HALF_LAST);
   wire rise_en = phase_en & ~MEM_CLK;
   wire fall_en = phase_en & MEM_CLK;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         div_r <= '0;
         MEM_CLK <= 1'b0;
      end else begin
         div_r <= phase_en ? '0 : div_r + CW'(1);
         MEM_CLK <= MEM_CLK ^ phase_en;
      end
   end

   // Software registers
   logic ctrl_dbgreq_r;
   logic [31:0] wdata_r;
   logic [31:0] rdata_r;
   logic absent_r, refused_r;
   logic dbg_state_r;
   cbd_state_t state_r, state_nxt;
   logic [1:0] op_r;

   // Write decode
   wire wr_ctrl = wr_en & (wr_addr == ADDR_CTRL) & wr_strb[0];
   wire wr_cmd = wr_en & (wr_addr == ADDR_CMD) & wr_strb[0];
   wire wr_wdata = wr_en & (wr_addr == ADDR_WDATA);
   wire resume = wr_ctrl & wr_data[CTRL_RESUME_BIT];
   wire [1:0] cmd_op = wr_data[CMD_OP_LSB +: 2];

   // Debug request gated by the static enable
   // enable gates request
   wire dbg_req_eff = dbg_en_s & (ext_req_s | ctrl_dbgreq_r);
   wire enter_dbg = dbg_req_eff & (state_r == CBD_IDLE) & ~dbg_state_r;

   // Command acceptance: only idle and outside debug
   wire can_start = (state_r == CBD_IDLE) & ~dbg_state_r & ~enter_dbg;
   wire accept = wr_cmd & can_start & (cmd_op != OP_NONE);
   wire refuse = wr_cmd & ~accept;
   wire [1:0] op_nxt = accept ? cmd_op : op_r;
   wire is_cop = (op_r == OP_COPROC);

   // Coprocessor verdict at memory clock rise
   // busy sampled while instruction low
   wire cop_sample = is_cop & (state_r == CBD_WAIT) & rise_en & ~COPROC_INSTR_OUT_N;
   wire cop_absent = cop_sample & absent_s;
   // busy low lets the operation start
   wire cop_go = cop_sample & ~absent_s & ~busy_s;
   wire cop_done = cop_absent | cop_go;

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         CBD_IDLE: begin
            if (accept) begin
               state_nxt = CBD_WAIT;
            end
         end
         CBD_WAIT: begin
            if (is_cop) begin
               if (cop_done) begin
                  state_nxt = CBD_IDLE;
               end
            end else if (rise_en) begin
               state_nxt = CBD_HIGH;
            end
         end
         CBD_HIGH: begin
            if (fall_en) begin
               state_nxt = CBD_LOW;
            end
         end
         CBD_LOW: begin
            if (rise_en) begin
               state_nxt = CBD_IDLE;
            end
         end
      endcase
   end

   // Read cycle spans from request to end of the low phase
   wire reading_nxt = (state_nxt != CBD_IDLE) & (op_nxt == OP_READ);
   wire writing_nxt = (state_nxt != CBD_IDLE) & (op_nxt == OP_WRITE);
   wire cop_nxt = (state_nxt != CBD_IDLE) & (op_nxt == OP_COPROC);

   // Falling-edge capture picks the bus that is configured
   // input bus sampled at fall
   wire [31:0] rd_bus = bus_cfg_s ? din_s : dbus_s;
   wire rd_capture = (op_r == OP_READ) & (state_r == CBD_HIGH) & fall_en;

   // Sequencer and operation registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_r <= CBD_IDLE;
         op_r <= OP_NONE;
         rdata_r <= DATA_RST;
         absent_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         if (rd_capture) begin
            rdata_r <= rd_bus;
         end
         if (accept) begin
            absent_r <= 1'b0;
         end else if (cop_done) begin
            absent_r <= cop_absent;
         end
      end
   end

   // Control and data registers written by software
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_dbgreq_r <= CTRL_DBGREQ_RST;
         wdata_r <= DATA_RST;
         refused_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_dbgreq_r <= wr_data[CTRL_DBGREQ_BIT];
         end
         if (wr_wdata) begin
            wdata_r <= merge(wdata_r, wr_data, wr_strb);
         end
         if (wr_cmd) begin
            refused_r <= refuse;
         end
      end
   end

   // Debug state: enable low forces it off
   // disable clears debug
   wire dbg_state_nxt = ~dbg_en_s ? 1'b0 : enter_dbg ? 1'b1 : resume ? 1'b0 : dbg_state_r;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dbg_state_r <= 1'b0;
      end else begin
         dbg_state_r <= dbg_state_nxt;
      end
   end

   // Pin outputs, all registered
   // output only with enable
   wire [31:0] dout_nxt = (bus_cfg_s & dbe_s) ? wdata_r : DATA_RST;
   wire oe_nxt = dbe_s & ~reading_nxt;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         DATA_BUS_O <= DATA_RST;
         DATA_BUS_OE <= 1'b0;
         DATA_OUT_BUS <= DATA_RST;
         MEM_WRITE <= 1'b0;
         COPROC_INSTR_OUT_N <= 1'b1;
         DEBUG_ACK_OUT <= 1'b0;
         INTERNAL_DEBUG_REQUEST_OUT <= 1'b0;
      end else begin
         DATA_BUS_O <= wdata_r;
         DATA_BUS_OE <= oe_nxt;
         DATA_OUT_BUS <= dout_nxt;
         MEM_WRITE <= writing_nxt;
         COPROC_INSTR_OUT_N <= ~cop_nxt;
         DEBUG_ACK_OUT <= dbg_state_nxt;
         INTERNAL_DEBUG_REQUEST_OUT <= ext_req_s | ctrl_dbgreq_r;
      end
   end

   // Read data multiplexer
   wire [31:0] status_w = {25'h0, dbg_en_s, dbe_s, bus_cfg_s, refused_r, absent_r,
                           dbg_state_r, state_r != CBD_IDLE};
   wire [31:0] ctrl_w = {30'h0, ctrl_dbgreq_r, 1'b0};
   wire [31:0] cmd_w = {30'h0, op_r};

   always_comb begin
      unique case (rd_addr)
         ADDR_CTRL: rd_data = ctrl_w;
         ADDR_CMD: rd_data = cmd_w;
         ADDR_WDATA: rd_data = wdata_r;
         ADDR_RDATA: rd_data = rdata_r;
         ADDR_STATUS: rd_data = status_w;
         default: rd_data = DATA_RST;
      endcase
   end
endmodule
`default_nettype wire
